// [swrb_regs.svh]
// register offsets, field positions, reset values and timing figures
// assumes a 256-byte register window on an ahb-lite bus, 32-bit words
`ifndef SWRB_REGS_SVH
`define SWRB_REGS_SVH

// byte offsets of the register words
`define SWRB_OFF_SW_CONTROL 8'h00
`define SWRB_OFF_CLK_MODE 8'h04
`define SWRB_OFF_BOOT_STATUS 8'h08
`define SWRB_OFF_UP_BRIDGE 8'h0C
`define SWRB_OFF_DN_BRIDGE 8'h10
`define SWRB_OFF_LINK_STATUS 8'h14
`define SWRB_OFF_RESET_STATUS 8'h18

// switch_control_reg fields
`define SWRB_HALT_BIT 0
`define SWRB_LOCK_BIT 1
// bridge_control_reg field
`define SWRB_SBR_BIT 0
// port_clocking_mode_reg field width
`define SWRB_MODE_MSB 1
// clock mode: low bit steers port 0, high bit the other ports
`define SWRB_MODE_PORT0_BIT 0
`define SWRB_MODE_OTHERS_BIT 1

// reset values
`define SWRB_MODE_RST 2'h0
`define SWRB_BOOT_RST 4'h0
`define SWRB_PIN_SYNC_RST 5'h00

// reset priority levels, 1 highest
`define SWRB_PRIO_NONE 3'h0
`define SWRB_PRIO_FUND 3'h1
`define SWRB_PRIO_HOT_TS1 3'h2
`define SWRB_PRIO_HOT_DL 3'h3
`define SWRB_PRIO_UP_SBR 3'h4
`define SWRB_PRIO_DN_SBR 3'h5

// clock figures in mhz
`define SWRB_CORE_CLK_MHZ 250
`define SWRB_REF_LOW_MHZ 100
`define SWRB_REF_HIGH_MHZ 125

// ahb-lite codes
`define SWRB_HSIZE_WORD 3'h2
`define SWRB_RESP_OKAY 1'h0

`endif

// [swrb_pkg.sv]
// types shared by the reset and boot-configuration block
// assumes nothing beyond a systemverilog compiler
package swrb_pkg;

   // kind of reset that a device or port is currently in
   typedef enum logic [2:0] {
      SWRB_KIND_NONE = 3'b000,
      SWRB_KIND_FUND = 3'b001,
      SWRB_KIND_HOT = 3'b010,
      SWRB_KIND_UP_SBR = 3'b011,
      SWRB_KIND_DN_SBR = 3'b100
   } swrb_kind_type;

   // boot configuration vector as captured from the pins
   typedef struct packed {
      logic halt;
      logic [1:0] clk_mode;
      logic ref_sel;
   } swrb_boot_type;

   // device reset status as presented to the core
   typedef struct packed {
      logic halted;
      swrb_kind_type kind;
      logic [2:0] level;
   } swrb_status_type;

endpackage

// [swrb_sync.sv]
// two-flop synchroniser for a group of independent pin levels
// assumes each bit is a slow level; no bus coherence between bits
`timescale 1ns/1ps
module swrb_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta; // first stage, read only by q

   // two stages, reset to a constant
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RST;
         q <= RST;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// [swrb_top.sv]
// reset arbiter, sticky registers and boot capture of a packet switch
// assumes hclk is the 250 mhz core clock and an ahb-lite master
`timescale 1ns/1ps
`include "swrb_regs.svh"
module swrb_top
   import swrb_pkg::*;
#(
   parameter int NPORTS = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic global_reset_n,
   input wire logic ref_freq_select,
   input wire logic [1:0] port_clock_mode_pins,
   input wire logic reset_halt,
   input wire logic hot_reset_ts1,
   input wire logic upstream_dl_down,
   output swrb_status_type rst_status,
   output logic fund_reset,
   output logic hot_reset,
   output logic [NPORTS-1:0] port_reset,
   output logic [NPORTS-1:0] common_clock,
   output logic ref_is_125
);

   // table of initial common-clock bits for a clock mode
   function automatic logic [NPORTS-1:0] cc_map(input logic [1:0] m);
      logic [NPORTS-1:0] v;
      v = {NPORTS{m[`SWRB_MODE_OTHERS_BIT]}};
      v[0] = m[`SWRB_MODE_PORT0_BIT];
      return v;
   endfunction

   // ---- pin synchronisers ----
   logic [4:0] pins_sync; // synchronised pin group
   logic glob_ok; // global reset pin released
   swrb_boot_type pin_boot; // live boot pins after synchroniser

   swrb_sync #(.W(5), .RST(`SWRB_PIN_SYNC_RST)) u_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .d({global_reset_n, reset_halt, port_clock_mode_pins,
          ref_freq_select}),
      .q(pins_sync)
   );
   assign glob_ok = pins_sync[4];
   assign pin_boot = swrb_boot_type'(pins_sync[3:0]);

   // ---- registers ----
   swrb_boot_type boot; // captured boot vector
   logic halt; // reset halt bit
   logic lock; // locks the clock-mode override
   logic [1:0] clk_mode; // port_clocking_mode_reg
   logic up_sbr; // upstream bridge secondary reset bit
   logic [NPORTS-1:0] dn_sbr; // downstream bridge reset bits
   logic [2:0] dev_level; // current winning priority
   swrb_kind_type dev_kind; // current device-wide reset kind
   logic fund_live; // fundamental reset condition now
   logic dev_wide; // fundamental or hot reset in force

   // ---- ahb-lite slave ----
   logic addr_ok; // address phase accepted
   logic dp_wr; // write data phase pending
   logic rd_wait; // read wait cycle, loads hrdata
   logic [7:0] dp_addr; // registered byte offset
   logic [31:0] rd_mux; // read data for dp_addr
   logic wr_ctrl, wr_mode, wr_up, wr_dn; // write strobes per register

   assign addr_ok = hsel & htrans[1] & hready;
   assign hreadyout = !rd_wait; // reads take one wait state
   assign hresp = `SWRB_RESP_OKAY;
   // capture the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr <= 1'b0;
         rd_wait <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_wr <= addr_ok & hwrite & (hsize == `SWRB_HSIZE_WORD);
         rd_wait <= addr_ok & !hwrite;
         if (addr_ok) begin
            dp_addr <= haddr[7:0];
         end
      end
   end

   // write strobes, decoded once the data phase is on the bus
   always_comb begin
      wr_ctrl = 1'b0;
      wr_mode = 1'b0;
      wr_up = 1'b0;
      wr_dn = 1'b0;
      if (!dp_wr) begin
         wr_ctrl = 1'b0; // no write pending
      end else if (dp_addr == `SWRB_OFF_SW_CONTROL) begin
         wr_ctrl = 1'b1;
      end else if (dp_addr == `SWRB_OFF_CLK_MODE) begin
         wr_mode = 1'b1;
      end else if (dp_addr == `SWRB_OFF_UP_BRIDGE) begin
         wr_up = 1'b1;
      end else if (dp_addr == `SWRB_OFF_DN_BRIDGE) begin
         wr_dn = 1'b1;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (dp_addr == `SWRB_OFF_SW_CONTROL) begin
         rd_mux[`SWRB_HALT_BIT] = halt;
         rd_mux[`SWRB_LOCK_BIT] = lock;
      end else if (dp_addr == `SWRB_OFF_CLK_MODE) begin
         rd_mux = 32'(clk_mode);
      end else if (dp_addr == `SWRB_OFF_BOOT_STATUS) begin
         rd_mux = 32'(boot); // boot pins as captured
      end else if (dp_addr == `SWRB_OFF_UP_BRIDGE) begin
         rd_mux[`SWRB_SBR_BIT] = up_sbr;
      end else if (dp_addr == `SWRB_OFF_DN_BRIDGE) begin
         rd_mux = 32'(dn_sbr);
      end else if (dp_addr == `SWRB_OFF_LINK_STATUS) begin
         rd_mux = 32'(common_clock);
      end else if (dp_addr == `SWRB_OFF_RESET_STATUS) begin
         rd_mux = 32'(rst_status);
      end
   end

   // read data flop, loaded in the wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_wait) begin
         hrdata <= rd_mux;
      end
   end

   // ---- boot capture ----
   assign fund_live = !glob_ok;
   // boot vector follows the pins only while the global reset holds
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         boot <= swrb_boot_type'(`SWRB_BOOT_RST);
      end else if (fund_live) begin
         boot <= pin_boot; // sampled only in fundamental reset
      end
   end

   // reference clock choice for the pll, fixed by the strap
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_is_125 <= 1'b0;
      end else begin
         ref_is_125 <= boot.ref_sel; // 100 or 125 mhz reference
      end
   end

   // ---- sticky control ----
   // halt: strap sets it in fundamental reset, software only clears
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         halt <= 1'b0;
      end else if (fund_live) begin
         halt <= pin_boot.halt; // set wins over a clearing write
      end else if (wr_ctrl && !hwdata[`SWRB_HALT_BIT]) begin
         halt <= 1'b0; // cleared by the smbus master
      end
   end

   // lock bit, switch sticky
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock <= 1'b0;
      end else if (fund_live) begin
         lock <= 1'b0; // fundamental reset or a write of zero restores it
      end else if (wr_ctrl) begin
         lock <= hwdata[`SWRB_LOCK_BIT];
      end
   end

   // clock mode: strap value, then writable while unlocked
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_mode <= `SWRB_MODE_RST;
      end else if (fund_live) begin
         clk_mode <= pin_boot.clk_mode;
      end else if (wr_mode && !lock) begin
         // writes land through smbus or eeprom loader
         clk_mode <= hwdata[`SWRB_MODE_MSB:0];
      end
   end

   // per-port common-clock bits of link_status_reg
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         common_clock <= '0;
      end else begin
         // one means shared reference clock advertised
         common_clock <= cc_map(clk_mode);
      end
   end

   // ---- bridge reset bits, cleared by any device-wide reset ----
   assign dev_wide = (dev_kind == SWRB_KIND_FUND) ||
                     (dev_kind == SWRB_KIND_HOT) || fund_live;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_sbr <= 1'b0;
      end else if (dev_wide) begin
         up_sbr <= 1'b0;
      end else if (wr_up) begin
         up_sbr <= hwdata[`SWRB_SBR_BIT];
      end
   end

   // port 0 is the upstream port and has no downstream bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dn_sbr <= '0;
      end else if (dev_wide) begin
         dn_sbr <= '0;
      end else if (wr_dn) begin
         dn_sbr <= hwdata[NPORTS-1:0] & ~NPORTS'(1);
      end
   end

   // ---- reset arbiter ----
   logic [2:0] next_level; // winning priority this cycle
   swrb_kind_type next_kind; // reset type of the winner
   logic [NPORTS-1:0] next_port; // per-port reset next cycle
   // priority encoder, evaluated anew every cycle
   always_comb begin
      next_level = `SWRB_PRIO_NONE;
      next_kind = SWRB_KIND_NONE;
      if (fund_live || halt) begin
         next_level = `SWRB_PRIO_FUND;
         next_kind = SWRB_KIND_FUND;
      end else if (hot_reset_ts1) begin
         next_level = `SWRB_PRIO_HOT_TS1;
         next_kind = SWRB_KIND_HOT;
      end else if (upstream_dl_down) begin
         next_level = `SWRB_PRIO_HOT_DL;
         next_kind = SWRB_KIND_HOT;
      end else if (up_sbr) begin
         next_level = `SWRB_PRIO_UP_SBR;
         next_kind = SWRB_KIND_UP_SBR;
      end else if (|dn_sbr) begin
         next_level = `SWRB_PRIO_DN_SBR;
         next_kind = SWRB_KIND_DN_SBR;
      end
   end

   // per-port reset: device-wide kinds hit all ports
   always_comb begin
      next_port = '0;
      if (next_kind == SWRB_KIND_FUND || next_kind == SWRB_KIND_HOT) begin
         next_port = '1;
      end else if (next_kind == SWRB_KIND_UP_SBR) begin
         next_port = ~NPORTS'(1); // all ports below the upstream port
      end else begin
         next_port = dn_sbr; // only the port concerned
      end
   end

   // the winner takes effect on the next edge, no settling
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dev_level <= `SWRB_PRIO_FUND;
         dev_kind <= SWRB_KIND_FUND;
         port_reset <= '1;
      end else begin
         dev_level <= next_level;
         dev_kind <= next_kind;
         port_reset <= next_port;
      end
   end

   // status outputs, all from flops
   assign rst_status = '{halted: halt, kind: dev_kind, level: dev_level};
   assign fund_reset = (dev_kind == SWRB_KIND_FUND);
   assign hot_reset = (dev_kind == SWRB_KIND_HOT);

   // ---- checks ----
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // core logic clocked by the 250 mhz core clock
   localparam int CORE_MHZ = `SWRB_CORE_CLK_MHZ;
   a_core_rate: assert property (CORE_MHZ == 250)
      else $error("core clock figure is not 250 mhz");
   sequence s_glob_held;
      !glob_ok [*2];
   endsequence
   a_fund_wins: assert property (
      s_glob_held |=> fund_reset && dev_level == `SWRB_PRIO_FUND
         && port_reset == '1)
      else $error("global reset did not win");
   a_hot_ts1: assert property (
      glob_ok && !halt && hot_reset_ts1
         |=> hot_reset && dev_level == `SWRB_PRIO_HOT_TS1)
      else $error("hot reset from ordered sets missed");
   a_same_type: assert property (
      dev_level == `SWRB_PRIO_HOT_TS1 && glob_ok && !halt
         && !hot_reset_ts1 && upstream_dl_down
         |=> hot_reset && dev_level == `SWRB_PRIO_HOT_DL)
      else $error("hot reset left while link still down");
   a_type_switch: assert property (
      hot_reset && glob_ok && !halt && !hot_reset_ts1
         && !upstream_dl_down && up_sbr && !fund_live
         |=> dev_kind == SWRB_KIND_UP_SBR && !port_reset[0])
      else $error("no switch to upstream secondary reset");
   a_port_only: assert property (
      dev_kind == SWRB_KIND_DN_SBR |-> port_reset == $past(dn_sbr))
      else $error("downstream reset spread to other ports");
   a_cc_table: assert property (
      $stable(clk_mode) [*2] |-> common_clock == cc_map(clk_mode))
      else $error("common clock bits disagree with mode");
   a_boot_frozen: assert property (
      glob_ok && $past(glob_ok) |-> $stable(boot))
      else $error("boot vector changed outside fundamental reset");
   sequence s_halt_release;
      !glob_ok ##1 glob_ok && halt;
   endsequence
   a_halt_hold: assert property (
      s_halt_release ##0 !wr_ctrl |=> fund_reset && halt ##1 fund_reset)
      else $error("device left reset while halted");
   a_sticky_keep: assert property (
      glob_ok && !wr_mode && !wr_ctrl |=> $stable(clk_mode)
         && $stable(lock))
      else $error("sticky field changed without fundamental reset");
   a_read_wait: assert property (
      addr_ok && !hwrite |=> !hreadyout ##1 hreadyout
         && hrdata == $past(rd_mux))
      else $error("read answer not one wait state");
endmodule

// [swrb_partner.sv]
// board reset source and upstream link model for the reset block
// assumes calls from one bench process, each just after a rising edge
`timescale 1ns/1ps
module swrb_partner (
   input wire logic hclk,
   output logic global_reset_n,
   output logic ref_freq_select,
   output logic [1:0] port_clock_mode_pins,
   output logic reset_halt,
   output logic hot_reset_ts1,
   output logic upstream_dl_down
);
   // power-up: reset pin low, straps low, link quiet
   initial begin
      global_reset_n = 1'b0;
      ref_freq_select = 1'b0;
      port_clock_mode_pins = 2'h0;
      reset_halt = 1'b0;
      hot_reset_ts1 = 1'b0;
      upstream_dl_down = 1'b0;
   end

   // move the global reset pin after the next edge
   task automatic pin(input logic v);
      @(posedge hclk);
      global_reset_n <= v;
   endtask

   // fundamental reset with straps, later the clock and reference straps wander
   task automatic boot(input logic [1:0] m, input logic r, input logic h);
      pin(1'b0);
      port_clock_mode_pins <= m;
      ref_freq_select <= r;
      reset_halt <= h;
      repeat (4) @(posedge hclk);
      pin(1'b1);
      repeat (6) @(posedge hclk);
      // shared strap pins get reused once out of reset
      {ref_freq_select, port_clock_mode_pins} <= 3'($urandom);
   endtask

   // upstream link levels: ordered sets and link-down
   task automatic link(input logic ts1, input logic dl);
      @(posedge hclk);
      hot_reset_ts1 <= ts1;
      upstream_dl_down <= dl;
   endtask
endmodule

// [tb_swrb_top.sv]
// self-checking bench for the reset arbiter and boot capture
// assumes swrb_partner drives pins; bus reads are checked by a watcher
`timescale 1ns/1ps
`include "swrb_regs.svh"
module tb_swrb_top
   import swrb_pkg::*;
;
   localparam int NP = 8; // port count
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hreadyout, hresp, dph_rd = 1'b0;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, m;
   logic [2:0] hsize;
   logic gr_n, rsel, halt_p, ts1, dld, fund_reset, hot_reset, ref_is_125, r;
   logic [1:0] mpins;
   swrb_status_type rst_status;
   logic [NP-1:0] port_reset, common_clock;
   logic [31:0] expq[$]; // expected read data, oldest first
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;

   // 250 mhz core clock
   always #2 hclk = ~hclk;

   swrb_top #(.NPORTS(NP)) u_swrb_top (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .global_reset_n(gr_n), .ref_freq_select(rsel),
      .port_clock_mode_pins(mpins), .reset_halt(halt_p),
      .hot_reset_ts1(ts1), .upstream_dl_down(dld),
      .rst_status(rst_status), .fund_reset(fund_reset),
      .hot_reset(hot_reset), .port_reset(port_reset),
      .common_clock(common_clock), .ref_is_125(ref_is_125));

   swrb_partner u_swrb_partner (.hclk(hclk), .global_reset_n(gr_n),
      .ref_freq_select(rsel), .port_clock_mode_pins(mpins),
      .reset_halt(halt_p), .hot_reset_ts1(ts1), .upstream_dl_down(dld));

   // compare one value and count it
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // counts, verdict and end of run
   task automatic test_done;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard, far beyond the fewer than two hundred cycles needed
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         test_done;
      end
   end

   // read watcher: oldest note is compared as a read completes
   always @(posedge hclk) begin
      if (dph_rd && hreadyout)
         chk(hrdata, expq.pop_front());
      if (hreadyout)
         dph_rd <= hsel && htrans[1] && !hwrite;
   end

   // one single word transfer, waits on hready in each phase
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= `SWRB_HSIZE_WORD;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask

   // write a register
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   // read a register, noting the expected word
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      xfer(a, 1'b0, $urandom);
   endtask

   // reset kind, level and per-port reset lines
   task automatic st(input swrb_kind_type k, input logic [2:0] l,
                     input logic [NP-1:0] p);
      chk(32'(rst_status[5:0]), 32'({k, l}));
      chk(32'(port_reset), 32'(p));
      chk(32'(fund_reset), 32'(k == SWRB_KIND_FUND));
      chk(32'(hot_reset), 32'(k == SWRB_KIND_HOT));
   endtask

   // main sequence
   initial begin
      void'($urandom(94));
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      // every clock-mode strap value through a fundamental reset
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         r = 1'($urandom);
         u_swrb_partner.boot(m, r, 1'b0);
         chk(32'(common_clock), 32'({{(NP-1){m[1]}}, m[0]}));
         chk(32'(ref_is_125), 32'(r));
         rd(`SWRB_OFF_BOOT_STATUS, {28'h0, 1'b0, m, r});
         st(SWRB_KIND_NONE, `SWRB_PRIO_NONE, '0);
      end
      $display("test boot straps done");
      // override survives hot resets, lock blocks it
      m = 2'($urandom);
      wr(`SWRB_OFF_CLK_MODE, 32'(m));
      repeat (2) @(posedge hclk);
      chk(32'(common_clock), 32'({{(NP-1){m[1]}}, m[0]}));
      u_swrb_partner.link(1'b1, 1'b1);
      repeat (2) @(posedge hclk);
      st(SWRB_KIND_HOT, `SWRB_PRIO_HOT_TS1, '1);
      u_swrb_partner.link(1'b0, 1'b1);
      repeat (2) @(posedge hclk);
      st(SWRB_KIND_HOT, `SWRB_PRIO_HOT_DL, '1);
      u_swrb_partner.link(1'b0, 1'b0);
      repeat (2) @(posedge hclk);
      rd(`SWRB_OFF_CLK_MODE, 32'(m));
      wr(`SWRB_OFF_SW_CONTROL, 32'h2);
      wr(`SWRB_OFF_CLK_MODE, 32'(~m));
      rd(`SWRB_OFF_CLK_MODE, 32'(m));
      u_swrb_partner.boot(2'h2, 1'b0, 1'b0);
      rd(`SWRB_OFF_CLK_MODE, 32'h2);
      $display("test sticky done");
      // secondary bus resets, ranked and confined
      wr(`SWRB_OFF_DN_BRIDGE, 32'h4);
      repeat (2) @(posedge hclk);
      st(SWRB_KIND_DN_SBR, `SWRB_PRIO_DN_SBR, NP'(4));
      wr(`SWRB_OFF_UP_BRIDGE, 32'h1);
      repeat (2) @(posedge hclk);
      st(SWRB_KIND_UP_SBR, `SWRB_PRIO_UP_SBR, ~NP'(1));
      wr(`SWRB_OFF_UP_BRIDGE, 32'h0);
      repeat (2) @(posedge hclk);
      st(SWRB_KIND_DN_SBR, `SWRB_PRIO_DN_SBR, NP'(4));
      wr(`SWRB_OFF_DN_BRIDGE, 32'h0);
      repeat (2) @(posedge hclk);
      st(SWRB_KIND_NONE, `SWRB_PRIO_NONE, '0);
      // hot reset over the upstream bridge bit, then back to that bit
      wr(`SWRB_OFF_UP_BRIDGE, 32'h1);
      u_swrb_partner.link(1'b1, 1'b0);
      u_swrb_partner.link(1'b0, 1'b0);
      @(posedge hclk);
      st(SWRB_KIND_HOT, `SWRB_PRIO_HOT_TS1, '1);
      @(posedge hclk);
      st(SWRB_KIND_UP_SBR, `SWRB_PRIO_UP_SBR, ~NP'(1));
      @(posedge hclk);
      st(SWRB_KIND_NONE, `SWRB_PRIO_NONE, '0);
      $display("test bridge resets done");
      // pin over ordered sets, then falls to hot reset
      u_swrb_partner.pin(1'b0);
      u_swrb_partner.link(1'b1, 1'b0);
      repeat (4) @(posedge hclk);
      st(SWRB_KIND_FUND, `SWRB_PRIO_FUND, '1);
      u_swrb_partner.pin(1'b1);
      repeat (4) @(posedge hclk);
      st(SWRB_KIND_HOT, `SWRB_PRIO_HOT_TS1, '1);
      u_swrb_partner.link(1'b0, 1'b0);
      $display("test priority fall done");
      // halt strap holds reset until software clears it
      u_swrb_partner.boot(2'h0, 1'b0, 1'b1);
      st(SWRB_KIND_FUND, `SWRB_PRIO_FUND, '1);
      chk(32'(rst_status.halted), 32'h1);
      wr(`SWRB_OFF_SW_CONTROL, 32'h0);
      repeat (2) @(posedge hclk);
      st(SWRB_KIND_NONE, `SWRB_PRIO_NONE, '0);
      $display("test halt done");
      // read-only and unmapped places
      wr(`SWRB_OFF_BOOT_STATUS, 32'hFFFFFFFF);
      rd(`SWRB_OFF_BOOT_STATUS, 32'h8);
      rd(8'h40, 32'h0);
      rd(`SWRB_OFF_RESET_STATUS, 32'h0);
      repeat (3) @(posedge hclk);
      chk(32'(hresp), 32'(`SWRB_RESP_OKAY));
      $display("test bus access done");
      test_done;
   end
endmodule
